/* File: cba_ctrl.sv */
// charge-balance converter control: modulator, phases, counting, ranging
`timescale 1ns/1ns
`default_nettype none
module cba_ctrl #(
  parameter logic [16:0] INTEG_LEN = cba_pkg::INTEG_CLOCKS,
  parameter logic [16:0] ZERO_LEN  = cba_pkg::ZERO_CLOCKS
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESET,
  input  wire logic                  COMP_IN,
  input  wire logic                  RANGE_AUTO_IN,
  input  wire logic                  RANGE_DN_IN,
  input  wire logic                  RANGE_UP_IN,
  input  wire logic [cba_pkg::FW-1:0] FUNC_IN,
  output var  logic                  CONV_CLK,
  output var  logic                  MODULATOR_PULSE_OUT,
  output var  logic                  CURRENT_SWITCH,
  output var  logic                  AZ_UPDATE,
  output var  logic                  CAL_UPDATE,
  output var  logic                  BUFFER_SELECT_FIRST_ZERO,
  output var  logic                  BUFFER_SELECT_REFERENCE,
  output var  logic                  BUFFER_SELECT_SECOND_ZERO,
  output var  logic                  BUFFER_SELECT_SIGNAL,
  output var  logic [cba_pkg::RW-1:0] RANGE_OUT,
  output var  logic [cba_pkg::FW-1:0] FUNC_OUT,
  output var  logic [cba_pkg::CW-1:0] RESULT_MAG,
  output var  logic                  RESULT_NEG,
  output var  logic                  OVERRANGE,
  output var  logic                  RESULT_STROBE
);
  import cba_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              comp_s;
  logic              auto_s;
  logic              dn_s;
  logic              up_s;
  logic [FW-1:0]     func_s;

  cba_sync #(.W(SYNC_W)) u_sync (
    .clk (SYS_CLK),
    .rst (RESET),
    .d   ({COMP_IN, RANGE_AUTO_IN, RANGE_DN_IN, RANGE_UP_IN, FUNC_IN}),
    .q   (pins_s)
  );

  assign {comp_s, auto_s, dn_s, up_s, func_s} = pins_s;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [2:0]    div_r,   div_nxt;
  logic [1:0]    qtr_r,   qtr_nxt;
  logic          mod_r,   mod_nxt;
  logic [CW-1:0] acc_r,   acc_nxt;
  logic [CW-1:0] tick_r,  tick_nxt;
  logic [CW-1:0] cnt_r,   cnt_nxt;
  cba_phase_t    ph_r,    ph_nxt;
  logic [RW-1:0] rng_r,   rng_nxt;
  logic          up_d_r,  up_d_nxt;
  logic          dn_d_r,  dn_d_nxt;
  logic          cclk_nxt, cur_nxt, az_nxt, cal_nxt;
  logic          sel_z1_nxt, sel_ref_nxt, sel_z2_nxt, sel_sig_nxt;
  logic [FW-1:0] func_nxt;
  logic [CW-1:0] mag_nxt;
  logic          neg_nxt, ovr_nxt, stb_nxt;

  // combinational helpers
  logic          qtick;
  logic          cedge;
  logic          forced;
  logic [CW-1:0] inc;
  logic [CW-1:0] sum;
  logic [CW-1:0] last;
  logic          ovr_now;
  logic [CW-1:0] fin;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    div_nxt  = div_r;
    qtr_nxt  = qtr_r;
    mod_nxt  = mod_r;
    acc_nxt  = acc_r;
    tick_nxt = tick_r;
    cnt_nxt  = cnt_r;
    ph_nxt   = ph_r;
    rng_nxt  = rng_r;
    mag_nxt  = RESULT_MAG;
    neg_nxt  = RESULT_NEG;
    ovr_nxt  = OVERRANGE;
    stb_nxt  = 1'b0;
    ovr_now  = 1'b0;
    fin      = cnt_r;
    up_d_nxt = up_s;
    dn_d_nxt = dn_s;
    func_nxt = func_s;

    // quarter-period ticks give the divide-by-two clock and its quadrature
    qtick = (div_r == QTR_LAST);
    if (qtick) begin
      div_nxt = 3'h0;
      qtr_nxt = 2'(qtr_r + 2'h1);
    end else begin
      div_nxt = 3'(div_r + 3'h1);
    end
    cedge = qtick && (qtr_r == Q_LAST);

    forced = (ph_r != SIGNAL_INTEGRATE);
    inc    = (ph_r == AUTO_CALIBRATE) ? FORCE_FULL_INC : FORCE_ZERO_INC;
    sum    = 17'(acc_r + inc);
    last   = (ph_r == SIGNAL_INTEGRATE) ? 17'(INTEG_LEN - 17'h1)
                                        : 17'(ZERO_LEN - 17'h1);

    if (cedge) begin
      if (forced) begin
        // rate accumulator: inc pulses per INTEG_CLOCKS converter clocks
        if (sum >= INTEG_CLOCKS) begin
          acc_nxt = 17'(sum - INTEG_CLOCKS);
          mod_nxt = 1'b1;
        end else begin
          acc_nxt = sum;
          mod_nxt = 1'b0;
        end
      end else begin
        mod_nxt = ~comp_s;
      end

      if (ph_r == SIGNAL_INTEGRATE && mod_nxt) begin
        cnt_nxt = 17'(cnt_r + 17'h1);
      end

      if (tick_r == last) begin
        tick_nxt = '0;
        unique case (ph_r)
          FIRST_ZERO:       ph_nxt = AUTO_CALIBRATE;
          AUTO_CALIBRATE:   ph_nxt = SECOND_ZERO;
          SECOND_ZERO:      ph_nxt = SIGNAL_INTEGRATE;
          SIGNAL_INTEGRATE: ph_nxt = FIRST_ZERO;
        endcase
        if (ph_r == SIGNAL_INTEGRATE) begin
          // the pulse set on this edge still belongs to this conversion
          fin     = cnt_nxt;
          cnt_nxt = '0;
          ovr_now = (fin < COUNT_SHIFT) || (fin > TOP_RAW);
          ovr_nxt = ovr_now;
          neg_nxt = (fin < ZERO_RAW);
          mag_nxt = (fin < ZERO_RAW) ? 17'(ZERO_RAW - fin)
                                     : 17'(fin - ZERO_RAW);
          stb_nxt = 1'b1;
          if (auto_s) begin
            if (ovr_now && rng_r != RANGE_TOP) begin
              rng_nxt = 3'(rng_r + 3'h1);
            end else if (!ovr_now && rng_r != 3'h0 &&
                         17'(mag_nxt) < DOWNRANGE_MAG) begin
              rng_nxt = 3'(rng_r - 3'h1);
            end
          end
        end
      end else begin
        tick_nxt = 17'(tick_r + 17'h1);
      end
    end

    // manual ranging reacts to edges of the up and down lines
    if (!auto_s) begin
      if (up_s && !up_d_r && rng_r != RANGE_TOP) begin
        rng_nxt = 3'(rng_r + 3'h1);
      end else if (dn_s && !dn_d_r && rng_r != 3'h0) begin
        rng_nxt = 3'(rng_r - 3'h1);
      end
    end

    // converter clock high in the first half of each period
    cclk_nxt = (qtr_nxt < Q_CLK_LOW);
    // current only in the middle two quarters: always an off time
    cur_nxt  = mod_nxt && (qtr_nxt >= Q_CUR_ON) && (qtr_nxt < Q_CUR_OFF);

    az_nxt      = (ph_nxt == FIRST_ZERO) || (ph_nxt == SECOND_ZERO);
    cal_nxt     = (ph_nxt == AUTO_CALIBRATE);
    sel_z1_nxt  = (ph_nxt == FIRST_ZERO);
    sel_ref_nxt = (ph_nxt == AUTO_CALIBRATE);
    sel_z2_nxt  = (ph_nxt == SECOND_ZERO);
    sel_sig_nxt = (ph_nxt == SIGNAL_INTEGRATE);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      div_r                     <= 3'h0;
      qtr_r                     <= 2'h0;
      mod_r                     <= 1'b0;
      acc_r                     <= '0;
      tick_r                    <= '0;
      cnt_r                     <= '0;
      ph_r                      <= FIRST_ZERO;
      rng_r                     <= RANGE_RST;
      up_d_r                    <= 1'b0;
      dn_d_r                    <= 1'b0;
      CONV_CLK                  <= 1'b1;
      MODULATOR_PULSE_OUT       <= 1'b0;
      CURRENT_SWITCH            <= 1'b0;
      AZ_UPDATE                 <= 1'b1;
      CAL_UPDATE                <= 1'b0;
      BUFFER_SELECT_FIRST_ZERO  <= 1'b1;
      BUFFER_SELECT_REFERENCE   <= 1'b0;
      BUFFER_SELECT_SECOND_ZERO <= 1'b0;
      BUFFER_SELECT_SIGNAL      <= 1'b0;
      RANGE_OUT                 <= RANGE_RST;
      FUNC_OUT                  <= '0;
      RESULT_MAG                <= '0;
      RESULT_NEG                <= 1'b0;
      OVERRANGE                 <= 1'b0;
      RESULT_STROBE             <= 1'b0;
    end else begin
      div_r                     <= div_nxt;
      qtr_r                     <= qtr_nxt;
      mod_r                     <= mod_nxt;
      acc_r                     <= acc_nxt;
      tick_r                    <= tick_nxt;
      cnt_r                     <= cnt_nxt;
      ph_r                      <= ph_nxt;
      rng_r                     <= rng_nxt;
      up_d_r                    <= up_d_nxt;
      dn_d_r                    <= dn_d_nxt;
      CONV_CLK                  <= cclk_nxt;
      MODULATOR_PULSE_OUT       <= mod_nxt;
      CURRENT_SWITCH            <= cur_nxt;
      AZ_UPDATE                 <= az_nxt;
      CAL_UPDATE                <= cal_nxt;
      BUFFER_SELECT_FIRST_ZERO  <= sel_z1_nxt;
      BUFFER_SELECT_REFERENCE   <= sel_ref_nxt;
      BUFFER_SELECT_SECOND_ZERO <= sel_z2_nxt;
      BUFFER_SELECT_SIGNAL      <= sel_sig_nxt;
      RANGE_OUT                 <= rng_nxt;
      FUNC_OUT                  <= func_nxt;
      RESULT_MAG                <= mag_nxt;
      RESULT_NEG                <= neg_nxt;
      OVERRANGE                 <= ovr_nxt;
      RESULT_STROBE             <= stb_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: cba_ctrl_chk.sv */
// port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module cba_ctrl_chk #(
  parameter logic [16:0] INTEG_LEN = 17'h00040,
  parameter logic [16:0] ZERO_LEN  = 17'h00008
) (
  input wire logic                   SYS_CLK,
  input wire logic                   RESET,
  input wire logic                   CONV_CLK,
  input wire logic                   MODULATOR_PULSE_OUT,
  input wire logic                   CURRENT_SWITCH,
  input wire logic                   AZ_UPDATE,
  input wire logic                   CAL_UPDATE,
  input wire logic                   BUFFER_SELECT_FIRST_ZERO,
  input wire logic                   BUFFER_SELECT_REFERENCE,
  input wire logic                   BUFFER_SELECT_SECOND_ZERO,
  input wire logic                   BUFFER_SELECT_SIGNAL,
  input wire logic [cba_pkg::CW-1:0] RESULT_MAG,
  input wire logic                   OVERRANGE,
  input wire logic                   RESULT_STROBE
);
  import cba_pkg::*;
  localparam int ZC1 = ZERO_LEN * 28 - 1;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence cur_on; ##13 CURRENT_SWITCH ##1 !CURRENT_SWITCH; endsequence
  sequence conv_cyc;
    ##13 CONV_CLK ##1 !CONV_CLK ##13 !CONV_CLK ##1 CONV_CLK;
  endsequence
  chk_current_gated: assert property (CURRENT_SWITCH |->
    MODULATOR_PULSE_OUT) else $error("current on without pulse");
  chk_current_half: assert property ($rose(CURRENT_SWITCH) |->
    cur_on) else $error("current pulse not half period");
  chk_current_centred: assert property ($rose(CONV_CLK) &&
    MODULATOR_PULSE_OUT |-> ##7 $rose(CURRENT_SWITCH))
    else $error("current pulse not centred");
  chk_current_gap: assert property ($fell(CURRENT_SWITCH) |->
    !CURRENT_SWITCH [*8]) else $error("current off gap too short");
  chk_conv_period: assert property ($rose(CONV_CLK) |->
    conv_cyc) else $error("converter clock period wrong");
  chk_pulse_edge: assert property ($changed(MODULATOR_PULSE_OUT) |->
    $rose(CONV_CLK)) else $error("pulse moved off converter edge");
  chk_select_onehot: assert property ($onehot({BUFFER_SELECT_FIRST_ZERO,
    BUFFER_SELECT_REFERENCE, BUFFER_SELECT_SECOND_ZERO,
    BUFFER_SELECT_SIGNAL})) else $error("buffer select not one-hot");
  chk_az_switch: assert property (AZ_UPDATE == (BUFFER_SELECT_FIRST_ZERO
    | BUFFER_SELECT_SECOND_ZERO)) else $error("zero storage switch wrong");
  chk_cal_switch: assert property (CAL_UPDATE ==
    BUFFER_SELECT_REFERENCE) else $error("cal storage switch wrong");
  chk_phase_order: assert property (($rose(BUFFER_SELECT_REFERENCE) |->
    $past(BUFFER_SELECT_FIRST_ZERO)) and ($rose(BUFFER_SELECT_SIGNAL)
    |-> $past(BUFFER_SELECT_SECOND_ZERO))) else $error("phase order wrong");
  chk_zero_length: assert property ($rose(BUFFER_SELECT_REFERENCE) |->
    ##ZC1 BUFFER_SELECT_REFERENCE ##1 BUFFER_SELECT_SECOND_ZERO)
    else $error("calibrate phase length wrong");
  chk_result_hold: assert property (!RESULT_STROBE |->
    $stable(RESULT_MAG) && $stable(OVERRANGE)) else $error("result moved");
  chk_strobe_phase: assert property (RESULT_STROBE |->
    $rose(BUFFER_SELECT_FIRST_ZERO)) else $error("strobe off cycle end");
endmodule
bind cba_ctrl cba_ctrl_chk #(.INTEG_LEN(INTEG_LEN), .ZERO_LEN(ZERO_LEN))
  u_chk (.SYS_CLK, .RESET, .CONV_CLK, .MODULATOR_PULSE_OUT, .CURRENT_SWITCH,
  .AZ_UPDATE, .CAL_UPDATE, .BUFFER_SELECT_FIRST_ZERO, .BUFFER_SELECT_SIGNAL,
  .BUFFER_SELECT_REFERENCE, .BUFFER_SELECT_SECOND_ZERO, .RESULT_MAG,
  .OVERRANGE, .RESULT_STROBE);
`default_nettype wire

/* File: cba_integ_model.sv */
// behavioural integrator and comparator on the converter far side
`timescale 1ns/1ns
`default_nettype none
module cba_integ_model (
  input  wire logic       SYS_CLK,
  input  wire logic       CURRENT_SWITCH,
  input  wire logic [7:0] rate,
  output var  logic       comp
);
  // reference charge is twice the largest input, so full input needs a
  // pulse every period; the rails clamp the integrator like the real one
  int level = 0;
  int nxt;
  always_comb nxt = level - int'(rate) + (CURRENT_SWITCH ? 200 : 0);
  always @(posedge SYS_CLK) begin
    level <= (nxt > 3000) ? 3000 : ((nxt < -3000) ? -3000 : nxt);
  end
  always_comb comp = (level >= 0);
endmodule
`default_nettype wire

/* File: cba_pkg.sv */
// constants and types for the charge-balance converter control block
// Operation
// - comparator output is inverted before the modulator flip-flop data input.
// - flip-flop sets on the next converter clock edge after data goes high.
// - flip-flop clears on the next converter clock edge after data goes low.
// - modulator stays idle until the integrator next falls below threshold.
// - current pulse lasts half the output pulse, centred by a quadrature phase.
// - converter clock is the oscillator divided by two; oscillator gives quadrature.
// - current switch has an off interval in every converter clock period.
// - counts are offset: negative full scale 0, zero 30000, positive 60000.
// - count span is shifted to centre on 66908 clocks of signal integrate.
// - auto-zero storage switch closes only during the two zero phases.
// - zero phases force switching at the midscale (zero input) rate.
// - calibrate phase closes calibration switch and forces the full-scale rate.
// - modulator pulses counted over integration form the conversion result.
// - tracks function and range, auto or manual ranging, drives range lines.
// - cycle runs first zero, calibrate, second zero, then signal integrate.
// - display subtracts the zero offset count and flags negative below it.
// - exactly one buffer input select is active, matching the current phase.
`default_nettype none
package cba_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 10000000;
  localparam int unsigned OSC_HZ     = 669000;
  // one quarter of a converter period is half an oscillator period
  localparam int unsigned QTR_DIV    = SYS_CLK_HZ / (2 * OSC_HZ);
  localparam logic [2:0]  QTR_LAST   = 3'(QTR_DIV - 1);
  localparam logic [1:0]  Q_LAST     = 2'h3;
  localparam logic [1:0]  Q_CUR_ON   = 2'h1;
  localparam logic [1:0]  Q_CUR_OFF  = 2'h3;
  localparam logic [1:0]  Q_CLK_LOW  = 2'h2;

  // ----------------------------------------------------------------------
  // count scale
  // ----------------------------------------------------------------------
  localparam int unsigned CW             = 17;
  localparam logic [16:0] INTEG_CLOCKS   = 17'h1055C;  // 66908
  localparam logic [16:0] ZERO_COUNTS    = 17'h07530;  // 30000
  localparam logic [16:0] FULL_COUNTS    = 17'h0EA60;  // 60000
  localparam logic [16:0] COUNT_SHIFT    = 17'(({15'h0, INTEG_CLOCKS[16:1]})
                                           - ({1'b0, FULL_COUNTS[16:1]}));
  localparam logic [16:0] ZERO_RAW       = 17'(COUNT_SHIFT + ZERO_COUNTS);
  localparam logic [16:0] TOP_RAW        = 17'(COUNT_SHIFT + FULL_COUNTS);
  localparam logic [16:0] FORCE_ZERO_INC = ZERO_RAW;
  localparam logic [16:0] FORCE_FULL_INC = TOP_RAW;
  localparam logic [16:0] ZERO_CLOCKS    = 17'h04000;
  localparam logic [16:0] DOWNRANGE_MAG  = 17'h00AF0;  // below 2800 steps down

  // ----------------------------------------------------------------------
  // ranging and function
  // ----------------------------------------------------------------------
  localparam int unsigned RW        = 3;
  localparam logic [2:0]  RANGE_TOP = 3'h4;
  localparam logic [2:0]  RANGE_RST = 3'h4;
  localparam int unsigned FW        = 3;
  localparam int unsigned SYNC_W    = 7;

  typedef enum logic [1:0] {
    FIRST_ZERO, AUTO_CALIBRATE, SECOND_ZERO, SIGNAL_INTEGRATE
  } cba_phase_t;
endpackage
`default_nettype wire

/* File: cba_sync.sv */
// two flip-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module cba_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: charge_balance_adc_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module charge_balance_adc_control_tb;
  import cba_pkg::*;
  // short phases keep one conversion cycle at 2464 clocks
  localparam logic [16:0] ZL = 17'h00008;
  localparam logic [16:0] IL = 17'h00040;
  logic        clk = 1'b0, rst = 1'b1, auto_r = 1'b1, dn = 1'b0, up = 1'b0;
  logic        comp, conv, mod, cur, az, cal, fz, rf, sz, sg, neg, ovr, stb;
  logic        cq, sq, fq, rq;
  logic [2:0]  func = 3'h0, rng, fo;
  logic [7:0]  rate = 8'h00;
  logic [16:0] mag;
  int          errors = 0, comparisons = 0, cyc = 0, n_sig, n_cal, n_zero;
  cba_ctrl #(.INTEG_LEN(IL), .ZERO_LEN(ZL)) DUT (.SYS_CLK(clk), .RESET(rst),
    .COMP_IN(comp), .RANGE_AUTO_IN(auto_r), .RANGE_DN_IN(dn),
    .RANGE_UP_IN(up), .FUNC_IN(func), .CONV_CLK(conv),
    .MODULATOR_PULSE_OUT(mod), .CURRENT_SWITCH(cur), .AZ_UPDATE(az),
    .CAL_UPDATE(cal), .BUFFER_SELECT_FIRST_ZERO(fz),
    .BUFFER_SELECT_REFERENCE(rf), .BUFFER_SELECT_SECOND_ZERO(sz),
    .BUFFER_SELECT_SIGNAL(sg), .RANGE_OUT(rng), .FUNC_OUT(fo),
    .RESULT_MAG(mag), .RESULT_NEG(neg), .OVERRANGE(ovr),
    .RESULT_STROBE(stb));
  cba_integ_model PM (.SYS_CLK(clk), .CURRENT_SWITCH(cur), .rate(rate),
    .comp(comp));
  initial forever #50 clk = ~clk;
  // a pulse is counted in the phase that was selected before its edge
  always @(posedge clk) begin
    cq <= conv;
    sq <= sg;
    fq <= fz;
    rq <= rf;
    if ((conv & ~cq & mod & sq) === 1'b1) n_sig <= n_sig + 1;
    if ((conv & ~cq & mod & rq) === 1'b1) n_cal <= n_cal + 1;
    if ((conv & ~cq & mod & fq) === 1'b1) n_zero <= n_zero + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, hi, g);
    comparisons++;
    if (g < lo || g > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // one extra edge lets the last pulse of the cycle land in the count
  task automatic to_strobe();
    for (int i = 0; i < 3000 && stb !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("strobe", 17'h00001, {16'h0, stb});
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset lines", 17'h00128, {8'h0, conv, mod, cur, az, cal, fz, rf,
      sz, sg});
    chk("reset range", 17'h00004, {14'h0, rng});
    chk("reset result", 17'h00000, mag);
  endtask
  task automatic t_convert(input logic [7:0] r, input int lo, hi);
    int n;
    @(posedge clk);
    rate <= r;
    to_strobe();
    n_sig = 0;
    n_cal = 0;
    n_zero = 0;
    to_strobe();
    n = n_sig;
    chk_in("signal pulses", lo, hi, n);
    chk_in("zero pulses", 3, 5, n_zero);
    chk_in("cal pulses", 6, 8, n_cal);
    chk("magnitude", (n < ZERO_RAW) ? ZERO_RAW - 17'(n) : 17'(n) - ZERO_RAW,
      mag);
    chk("negative", {16'h0, n < ZERO_RAW}, {16'h0, neg});
    chk("overrange", {16'h0, n < COUNT_SHIFT || n > TOP_RAW},
      {16'h0, ovr});
  endtask
  task automatic press(input logic is_up, input logic [2:0] e);
    @(posedge clk);
    if (is_up) up <= 1'b1;
    else dn <= 1'b1;
    repeat (4) @(posedge clk);
    up <= 1'b0;
    dn <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("range", {14'h0, e}, {14'h0, rng});
  endtask
  task automatic t_range();
    @(posedge clk);
    auto_r <= 1'b0;
    func <= 3'h5;
    press(1'b1, 3'h4);
    chk("function", 17'h00005, {14'h0, fo});
    press(1'b0, 3'h3);
    press(1'b0, 3'h2);
    press(1'b1, 3'h3);
    press(1'b0, 3'h2);
    @(posedge clk);
    auto_r <= 1'b1;
    to_strobe();
    repeat (4) @(posedge clk);
    // small counts are always overrange, so autorange steps up once
    press(1'b0, 3'h3);
  endtask
  initial begin
    t_reset();
    t_convert(8'h64, 60, 64);
    t_convert(8'h32, 28, 36);
    t_convert(8'h00, 0, 0);
    t_range();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
